//--- core/mai_pkg.sv
// Shared constants and types for the motion axis I/O block
package mai_pkg;

	// Number of axes and encoder channels
	localparam int MAI_AXES = 6;

	// Register offsets inside one axis window (axis index is address bits 7:5)
	localparam logic [4:0] MAI_REG_CTRL = 5'h00;
	localparam logic [4:0] MAI_REG_DAC_CMD = 5'h04;
	localparam logic [4:0] MAI_REG_DAC_LIM = 5'h08;
	localparam logic [4:0] MAI_REG_DAC_OFF = 5'h0C;
	localparam logic [4:0] MAI_REG_STEP = 5'h10;
	localparam logic [4:0] MAI_REG_STATUS = 5'h14;
	localparam logic [4:0] MAI_REG_ENC_CNT = 5'h18;
	localparam logic [4:0] MAI_REG_ENC_IDX = 5'h1C;

	// Control register fields: persistent bits 12:0, write-one strobes above
	localparam int MAI_CTRL_W = 13;
	localparam int C_STEP_MODE = 0;
	localparam int C_STEP_POL = 1;
	localparam int C_DIR_POL = 2;
	localparam int C_INH_POL = 3;
	localparam int C_INH_SW = 4;
	localparam int C_FWD_EN = 5;
	localparam int C_REV_EN = 6;
	localparam int C_HOME_EN = 7;
	localparam int C_FWD_POL = 8;
	localparam int C_REV_POL = 9;
	localparam int C_HOME_POL = 10;
	localparam int C_HOME_DIR = 11;
	localparam int C_HOME_APPR = 12;
	localparam int C_HOME_GO = 13;
	localparam int C_KILL = 14;
	localparam int C_KILL_CLR = 15;
	localparam int C_IDX_ARM = 16;
	// Step command register: count in 15:0, direction in bit 16
	localparam int S_DIR = 16;
	localparam logic [MAI_CTRL_W-1:0] MAI_CTRL_RST = 13'h0010;

	// Step pulse timing
	localparam int MAI_CLK_NS = 25;
	localparam int MAI_STEP_HI_NS = 1000;
	localparam int MAI_STEP_LO_NS = 1000;
	localparam logic [5:0] MAI_STEP_HI_CYC = 6'((MAI_STEP_HI_NS + MAI_CLK_NS - 1) / MAI_CLK_NS);
	localparam logic [5:0] MAI_STEP_LO_CYC = 6'((MAI_STEP_LO_NS + MAI_CLK_NS - 1) / MAI_CLK_NS);

	// Home search sequence
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SEEK = 2'b01,
		HS_BACKOFF = 2'b10,
		HS_CREEP = 2'b11
	} mai_home_t;

endpackage

//--- core/mai_axis_io.sv
// Motion axis I/O: DAC codes, stepper pulses, inhibits, limits, home search, encoders
`timescale 1ns/1ps
`default_nettype none
module mai_axis_io
	import mai_pkg::*;
#(
	parameter int N_AXES = MAI_AXES
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output var logic [31:0] o_wb_dat,
	output var logic o_wb_ack,
	input wire logic [N_AXES-1:0] i_fwd_limit,
	input wire logic [N_AXES-1:0] i_rev_limit,
	input wire logic [N_AXES-1:0] i_home,
	input wire logic [N_AXES-1:0] i_kill_req,
	input wire logic [N_AXES-1:0] i_enc_a,
	input wire logic [N_AXES-1:0] i_enc_b,
	input wire logic [N_AXES-1:0] i_enc_index,
	output var logic [N_AXES-1:0] o_step_or_fwd_pulse_out,
	output var logic [N_AXES-1:0] o_direction_or_rev_pulse_out,
	output var logic [N_AXES-1:0] o_inhibit,
	output var logic [N_AXES-1:0][15:0] o_dac_code
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [N_AXES-1:0][MAI_CTRL_W-1:0] ctrl;
		logic [N_AXES-1:0][15:0] dac_cmd, dac_off, dac_out;
		logic [N_AXES-1:0][14:0] dac_lim;
		logic [N_AXES-1:0][15:0] pend;
		logic [N_AXES-1:0] dir, odir, pulse;
		logic [N_AXES-1:0][5:0] ph_cnt;
		mai_home_t [N_AXES-1:0] hs;
		logic [N_AXES-1:0] revd, home_done, kill, lim_halt;
		logic [N_AXES-1:0][2:0] lim_prev;
		logic [N_AXES-1:0][2:0] sync1, sync2, hist, filt;
		logic [N_AXES-1:0][31:0] count, idx_pos;
		logic [N_AXES-1:0] idx_arm, idx_cap;
		logic [N_AXES-1:0] step_o, dir_o, inh_o;
	} mai_state_t;

	// Enum member gets its own pattern; a bare zero fill is not enum-compatible
	localparam mai_state_t ST_RST = '{ctrl: {N_AXES{MAI_CTRL_RST}},
		hs: '{default: HS_IDLE}, default: '0};

	mai_state_t st;
	mai_state_t next_st;

	logic [N_AXES-1:0] lv_fwd, lv_rev, lv_home;
	logic [N_AXES-1:0] act_fwd, act_rev, act_home;
	logic [N_AXES-1:0] edg_fwd, edg_rev, edg_home;
	logic [N_AXES-1:0][2:0] enc_nf;
	logic [N_AXES-1:0] enc_step, enc_up, idx_rise;
	logic [N_AXES-1:0][15:0] dac_calc;
	logic [N_AXES-1:0] wr_step, wr_home, wr_kill, wr_kclr, wr_arm, wr_cnt;
	logic [31:0] wr_val;
	logic wb_req;
	logic [2:0] wb_ax;
	logic wb_ax_ok;

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] mai_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign wb_req = i_wb_cyc & i_wb_stb & ~st.ack;
	assign wb_ax = i_wb_adr[7:5];
	assign wb_ax_ok = (32'(wb_ax) < 32'(N_AXES));

	// Per-axis input conditioning, encoder decode and DAC arithmetic
	for (genvar g = 0; g < N_AXES; g++)
	begin : g_axis
		logic [2:0] eq;
		logic signed [17:0] c_raw, c_lim, c_clp, c_sum;

		// Logical input level is the pin after polarity; always visible in status
		assign lv_fwd[g] = i_fwd_limit[g] ^ st.ctrl[g][C_FWD_POL];
		assign lv_rev[g] = i_rev_limit[g] ^ st.ctrl[g][C_REV_POL];
		assign lv_home[g] = i_home[g] ^ st.ctrl[g][C_HOME_POL];
		assign act_fwd[g] = lv_fwd[g] & st.ctrl[g][C_FWD_EN];
		assign act_rev[g] = lv_rev[g] & st.ctrl[g][C_REV_EN];
		assign act_home[g] = lv_home[g] & st.ctrl[g][C_HOME_EN];
		// Enabling an input that is already active counts as an edge
		assign edg_fwd[g] = act_fwd[g] & ~st.lim_prev[g][0];
		assign edg_rev[g] = act_rev[g] & ~st.lim_prev[g][1];
		assign edg_home[g] = act_home[g] & ~st.lim_prev[g][2];

		// Filter: a level passes only after two equal synchronised samples
		assign eq = ~(st.sync2[g] ^ st.hist[g]);
		assign enc_nf[g] = (st.sync2[g] & eq) | (st.filt[g] & ~eq);
		// Exactly one phase moved; both moving at once is dropped
		assign enc_step[g] = (enc_nf[g][0] ^ st.filt[g][0]) ^ (enc_nf[g][1] ^ st.filt[g][1]);
		// A leading B counts up, every edge of either phase counts
		assign enc_up[g] = enc_nf[g][0] ^ st.filt[g][1];
		assign idx_rise[g] = enc_nf[g][2] & ~st.filt[g][2];

		// Clamp to the symmetric window, add offset, saturate to 16 bits
		assign c_raw = 18'(signed'(st.dac_cmd[g]));
		assign c_lim = signed'({3'b000, st.dac_lim[g]});
		assign c_clp = (c_raw > c_lim) ? c_lim : ((c_raw < -c_lim) ? -c_lim : c_raw);
		assign c_sum = c_clp + 18'(signed'(st.dac_off[g]));
		assign dac_calc[g] = (c_sum > 18'sd32767) ? 16'h7FFF :
			((c_sum < -18'sd32768) ? 16'h8000 : c_sum[15:0]);
	end

	// Next-state logic: bus first, then hardware events so sets win over clears
	always_comb
	begin
		next_st = st;
		wr_step = '0;
		wr_home = '0;
		wr_kill = '0;
		wr_kclr = '0;
		wr_arm = '0;
		wr_cnt = '0;
		wr_val = 32'h0000_0000;

		// Wishbone slave: one-cycle ack, unmapped reads give zero
		next_st.ack = wb_req;
		next_st.rdat = 32'h0000_0000;
		if (wb_req && wb_ax_ok)
		begin
			case (i_wb_adr[4:0])
				MAI_REG_CTRL: next_st.rdat = {19'h0, st.ctrl[wb_ax]};
				MAI_REG_DAC_CMD: next_st.rdat = {16'h0, st.dac_cmd[wb_ax]};
				MAI_REG_DAC_LIM: next_st.rdat = {17'h0, st.dac_lim[wb_ax]};
				MAI_REG_DAC_OFF: next_st.rdat = {16'h0, st.dac_off[wb_ax]};
				MAI_REG_STEP: next_st.rdat = {15'h0, st.dir[wb_ax], st.pend[wb_ax]};
				MAI_REG_STATUS: next_st.rdat = {22'h0, st.hs[wb_ax], st.idx_cap[wb_ax],
					st.home_done[wb_ax], st.lim_halt[wb_ax], st.kill[wb_ax],
					(st.pend[wb_ax] != 16'h0000) || (st.hs[wb_ax] != HS_IDLE),
					lv_home[wb_ax], lv_rev[wb_ax], lv_fwd[wb_ax]};
				MAI_REG_ENC_CNT: next_st.rdat = st.count[wb_ax];
				MAI_REG_ENC_IDX: next_st.rdat = st.idx_pos[wb_ax];
				default: next_st.rdat = 32'h0000_0000;
			endcase
			if (i_wb_we)
			begin
				case (i_wb_adr[4:0])
					MAI_REG_CTRL:
					begin
						wr_val = mai_merge({19'h0, st.ctrl[wb_ax]}, i_wb_dat, i_wb_sel);
						next_st.ctrl[wb_ax] = wr_val[MAI_CTRL_W-1:0];
						wr_home[wb_ax] = wr_val[C_HOME_GO];
						wr_kill[wb_ax] = wr_val[C_KILL];
						wr_kclr[wb_ax] = wr_val[C_KILL_CLR];
						wr_arm[wb_ax] = wr_val[C_IDX_ARM];
					end
					MAI_REG_DAC_CMD:
					begin
						wr_val = mai_merge({16'h0, st.dac_cmd[wb_ax]}, i_wb_dat, i_wb_sel);
						next_st.dac_cmd[wb_ax] = wr_val[15:0];
					end
					MAI_REG_DAC_LIM:
					begin
						wr_val = mai_merge({17'h0, st.dac_lim[wb_ax]}, i_wb_dat, i_wb_sel);
						next_st.dac_lim[wb_ax] = wr_val[14:0];
					end
					MAI_REG_DAC_OFF:
					begin
						wr_val = mai_merge({16'h0, st.dac_off[wb_ax]}, i_wb_dat, i_wb_sel);
						next_st.dac_off[wb_ax] = wr_val[15:0];
					end
					MAI_REG_STEP:
					begin
						wr_val = mai_merge(32'h0000_0000, i_wb_dat, i_wb_sel);
						wr_step[wb_ax] = 1'b1;
					end
					MAI_REG_ENC_CNT:
					begin
						wr_val = mai_merge(st.count[wb_ax], i_wb_dat, i_wb_sel);
						wr_cnt[wb_ax] = 1'b1;
					end
					default:
					begin
						wr_val = 32'h0000_0000;
					end
				endcase
			end
		end

		for (int i = 0; i < N_AXES; i++)
		begin
			// Encoder synchroniser, filter and counter
			next_st.sync1[i] = {i_enc_index[i], i_enc_b[i], i_enc_a[i]};
			next_st.sync2[i] = st.sync1[i];
			next_st.hist[i] = st.sync2[i];
			next_st.filt[i] = enc_nf[i];
			if (wr_cnt[i])
			begin
				next_st.count[i] = wr_val;
			end
			else if (enc_step[i])
			begin
				next_st.count[i] = enc_up[i] ? st.count[i] + 32'h1 : st.count[i] - 32'h1;
			end

			// Index capture; arming takes effect next cycle, so an edge in the arming cycle is missed
			if (wr_arm[i])
			begin
				next_st.idx_arm[i] = 1'b1;
				next_st.idx_cap[i] = 1'b0;
			end
			if (st.idx_arm[i] && idx_rise[i])
			begin
				next_st.idx_pos[i] = st.count[i];
				next_st.idx_cap[i] = 1'b1;
				next_st.idx_arm[i] = 1'b0;
			end

			// Kill latch: kill requests and software kill beat a clear
			if (wr_kclr[i])
			begin
				next_st.kill[i] = 1'b0;
			end
			if (wr_kill[i] || i_kill_req[i])
			begin
				next_st.kill[i] = 1'b1;
			end

			// New step command, refused into an active limit
			if (wr_step[i] && !next_st.kill[i] && st.hs[i] == HS_IDLE &&
				!(!wr_val[S_DIR] && act_fwd[i]) && !(wr_val[S_DIR] && act_rev[i]))
			begin
				next_st.pend[i] = wr_val[15:0];
				next_st.dir[i] = wr_val[S_DIR];
				next_st.lim_halt[i] = 1'b0;
			end

			// Home search start only with all three inputs enabled
			if (wr_home[i] && !next_st.kill[i] && st.hs[i] == HS_IDLE && st.ctrl[i][C_FWD_EN] &&
				st.ctrl[i][C_REV_EN] && st.ctrl[i][C_HOME_EN])
			begin
				next_st.hs[i] = HS_SEEK;
				next_st.dir[i] = st.ctrl[i][C_HOME_DIR];
				next_st.revd[i] = 1'b0;
				next_st.home_done[i] = 1'b0;
				next_st.pend[i] = 16'h0000;
			end

			// Limit and home events, per search phase
			case (next_st.hs[i])
				HS_IDLE:
				begin
					if (edg_fwd[i] || edg_rev[i] || edg_home[i])
					begin
						next_st.pend[i] = 16'h0000;
						next_st.lim_halt[i] = 1'b1;
					end
					// Only a limit still active blocks; a past pulse does not
					if ((act_fwd[i] && !next_st.dir[i]) || (act_rev[i] && next_st.dir[i]))
					begin
						next_st.pend[i] = 16'h0000;
					end
				end
				HS_SEEK:
				begin
					if (edg_home[i])
					begin
						if (st.ctrl[i][C_HOME_APPR])
						begin
							next_st.hs[i] = HS_BACKOFF;
							next_st.dir[i] = ~st.ctrl[i][C_HOME_DIR];
						end
						else
						begin
							next_st.hs[i] = HS_IDLE;
							next_st.home_done[i] = 1'b1;
						end
					end
					else if (((edg_fwd[i] && !next_st.dir[i]) || (edg_rev[i] && next_st.dir[i])) &&
						!next_st.revd[i])
					begin
						next_st.dir[i] = ~next_st.dir[i];
						next_st.revd[i] = 1'b1;
					end
					else if (edg_fwd[i] || edg_rev[i])
					begin
						next_st.hs[i] = HS_IDLE;
						next_st.lim_halt[i] = 1'b1;
					end
				end
				HS_BACKOFF:
				begin
					if (edg_fwd[i] || edg_rev[i])
					begin
						next_st.hs[i] = HS_IDLE;
						next_st.lim_halt[i] = 1'b1;
					end
					else if (!act_home[i])
					begin
						next_st.hs[i] = HS_CREEP;
						next_st.dir[i] = st.ctrl[i][C_HOME_DIR];
					end
				end
				HS_CREEP:
				begin
					if (edg_fwd[i] || edg_rev[i])
					begin
						next_st.hs[i] = HS_IDLE;
						next_st.lim_halt[i] = 1'b1;
					end
					else if (edg_home[i])
					begin
						next_st.hs[i] = HS_IDLE;
						next_st.home_done[i] = 1'b1;
					end
				end
				default:
				begin
					next_st.hs[i] = HS_IDLE;
				end
			endcase
			next_st.lim_prev[i] = {act_home[i], act_rev[i], act_fwd[i]};

			// Kill ends the pending move and any home search at once
			if (next_st.kill[i])
			begin
				next_st.pend[i] = 16'h0000;
				next_st.hs[i] = HS_IDLE;
			end

			// Pulse timer; a started pulse always finishes at full width
			if (st.ph_cnt[i] != 6'h00)
			begin
				next_st.ph_cnt[i] = st.ph_cnt[i] - 6'h01;
			end
			else if (st.pulse[i])
			begin
				next_st.pulse[i] = 1'b0;
				next_st.ph_cnt[i] = MAI_STEP_LO_CYC - 6'h01;
			end
			else if (next_st.hs[i] != HS_IDLE || next_st.pend[i] != 16'h0000)
			begin
				next_st.pulse[i] = 1'b1;
				next_st.ph_cnt[i] = MAI_STEP_HI_CYC - 6'h01;
				if (next_st.hs[i] == HS_IDLE)
				begin
					next_st.pend[i] = next_st.pend[i] - 16'h0001;
				end
			end
			// Direction is frozen while a pulse is high so CW/CCW never splits one
			next_st.odir[i] = next_st.pulse[i] ? (st.pulse[i] ? st.odir[i] : next_st.dir[i])
				: next_st.dir[i];

			// Output formatting
			if (st.ctrl[i][C_STEP_MODE])
			begin
				next_st.step_o[i] = (next_st.pulse[i] & ~next_st.odir[i]) ^ st.ctrl[i][C_STEP_POL];
				next_st.dir_o[i] = (next_st.pulse[i] & next_st.odir[i]) ^ st.ctrl[i][C_DIR_POL];
			end
			else
			begin
				next_st.step_o[i] = next_st.pulse[i] ^ st.ctrl[i][C_STEP_POL];
				next_st.dir_o[i] = next_st.odir[i] ^ st.ctrl[i][C_DIR_POL];
			end
			// Inhibit polarity bit set means active-high
			next_st.inh_o[i] = (next_st.kill[i] | st.ctrl[i][C_INH_SW]) ~^ st.ctrl[i][C_INH_POL];
			next_st.dac_out[i] = dac_calc[i];
		end
	end

	// State register
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st <= ST_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state register
	assign o_wb_ack = st.ack;
	assign o_wb_dat = st.rdat;
	assign o_step_or_fwd_pulse_out = st.step_o;
	assign o_direction_or_rev_pulse_out = st.dir_o;
	assign o_inhibit = st.inh_o;
	assign o_dac_code = st.dac_out;

endmodule
`default_nettype wire

//--- tb/mai_axis_io_monitor.sv
// Checker on the motion axis I/O block ports
`timescale 1ns/1ps
`default_nettype none
module mai_axis_io_monitor
#(
	parameter int N_AXES = 6
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [N_AXES-1:0] i_kill_req,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [N_AXES-1:0] o_step_or_fwd_pulse_out,
	input wire logic [N_AXES-1:0] o_direction_or_rev_pulse_out,
	input wire logic [N_AXES-1:0] o_inhibit,
	input wire logic [N_AXES-1:0][15:0] o_dac_code
);
	logic [3:0] age;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Cycles since the last write or kill request; saturates so it never wraps
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			age <= 4'h0;
		else if ((i_wb_cyc && i_wb_we) || (|i_kill_req))
			age <= 4'h0;
		else if (age != 4'hF)
			age <= age + 4'h1;
	end
	// Bus request not yet answered
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// Level held for eight cycles
	sequence s_hold8(sig);
		$stable(sig)[*8];
	endsequence
	a_ack_follows_req: assert property (s_req |=> o_wb_ack) else $error("ack missing");
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data leak");
	a_step_width_held: assert property ($changed(o_step_or_fwd_pulse_out[0]) |=>
		s_hold8(o_step_or_fwd_pulse_out[0])) else $error("step pulse too short");
	a_dir_level_held: assert property ($changed(o_direction_or_rev_pulse_out[0]) |=>
		s_hold8(o_direction_or_rev_pulse_out[0])) else $error("dir level too short");
	a_inhibit_has_cause: assert property ($changed(o_inhibit) |-> age <= 4'h6)
		else $error("inhibit moved without cause");
	a_dac_has_cause: assert property ($changed(o_dac_code) |-> age <= 4'h6)
		else $error("dac moved without write");
endmodule
bind mai_axis_io mai_axis_io_monitor #(.N_AXES(N_AXES)) u_mai_axis_io_monitor (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_kill_req(i_kill_req), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_step_or_fwd_pulse_out(o_step_or_fwd_pulse_out),
	.o_direction_or_rev_pulse_out(o_direction_or_rev_pulse_out),
	.o_inhibit(o_inhibit), .o_dac_code(o_dac_code));
`default_nettype wire

//--- tb/mai_far_side.sv
// Far-side model: stepper drive turning a shaft that carries a quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module mai_far_side
(
	input wire logic i_clk,
	input wire logic i_mode,
	input wire logic i_step,
	input wire logic i_dir,
	output var logic o_enc_a,
	output var logic o_enc_b,
	output var int o_n_fwd,
	output var int o_n_rev
);
	logic step_q = 1'b0;
	logic dir_q = 1'b0;
	logic [1:0] pos = 2'h0;
	logic fwd_p;
	logic rev_p;
	// Active-high drive only; an inverted output would be counted on its idle edge
	assign fwd_p = i_step && !step_q && (i_mode || !i_dir);
	assign rev_p = i_mode ? (i_dir && !dir_q) : (i_step && !step_q && i_dir);
	// Two phases a quarter cycle apart, A leading on forward travel
	assign o_enc_a = pos[1] ^ pos[0];
	assign o_enc_b = pos[1];
	initial
	begin
		o_n_fwd = 0;
		o_n_rev = 0;
	end
	// One encoder state per step taken
	always @(posedge i_clk)
	begin
		step_q <= i_step;
		dir_q <= i_dir;
		o_n_fwd <= o_n_fwd + int'(fwd_p);
		o_n_rev <= o_n_rev + int'(rev_p);
		pos <= pos + 2'(fwd_p) - 2'(rev_p);
	end
endmodule
`default_nettype wire

//--- tb/mai_axis_io_tb_top.sv
// Testbench for the motion axis I/O block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mai_axis_io_tb_top
	import mai_pkg::*;
;
	localparam int N = MAI_AXES;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mode = 1'b0, m_a, m_b;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rd, q;
	logic [N-1:0] fwd = '0, rev = '0, home = '0, kill = '0, eidx = '0, ea_tb = '0, eb_tb = '0;
	logic [N-1:0] ea, eb, stp, dir, inh;
	logic [N-1:0][15:0] dac;
	logic [1:0] up[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
	logic [1:0] dn[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	int nf, nr, ef = 0, er = 0, snap, n_errors = 0, num_checks = 0;
	assign ea = {ea_tb[N-1:1], m_a};
	assign eb = {eb_tb[N-1:1], m_b};
	always #12.5 clk = ~clk;
	mai_axis_io u_mai_axis_io (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_fwd_limit(fwd), .i_rev_limit(rev), .i_home(home), .i_kill_req(kill),
		.i_enc_a(ea), .i_enc_b(eb), .i_enc_index(eidx), .o_step_or_fwd_pulse_out(stp),
		.o_direction_or_rev_pulse_out(dir), .o_inhibit(inh), .o_dac_code(dac));
	mai_far_side u_mai_far_side (.i_clk(clk), .i_mode(mode), .i_step(stp[0]), .i_dir(dir[0]),
		.o_enc_a(m_a), .o_enc_b(m_b), .o_n_fwd(nf), .o_n_rev(nr));
	// Classic single cycle; data taken at the edge where ack is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hF};
		// No cycle count assumed; a lost ack is caught by the watchdog
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		q = rd;
		{cyc, stb, we} <= 3'h0;
	endtask
	// Step command, then time for every pulse of it
	task automatic steps(input logic [31:0] v, input int n);
		xfer(1'b1, 8'h10, v);
		repeat (n * 80 + 20) @(posedge clk);
	endtask
	// Encoder state on axis one
	task automatic quad(input logic [1:0] ab, input int gap);
		@(posedge clk) {ea_tb[1], eb_tb[1]} <= ab;
		repeat (gap) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial
	begin
		#500000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		xfer(1'b0, 8'h00, 32'h0);
		`CHK(q, 32'(MAI_CTRL_RST))
		`CHK(inh[0], 1'b0)
		xfer(1'b0, 8'hE0, 32'h0);
		`CHK(q, 32'h0)
		// Inhibit: direct drive, polarity, kill command and kill request
		xfer(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge clk);
		`CHK(inh[0], 1'b1)
		xfer(1'b1, 8'h00, 32'h8);
		repeat (4) @(posedge clk);
		`CHK(inh[0], 1'b0)
		xfer(1'b1, 8'h00, 32'h4008);
		repeat (4) @(posedge clk);
		`CHK(inh[0], 1'b1)
		xfer(1'b1, 8'h00, 32'h8008);
		@(posedge clk) kill[0] <= 1'b1;
		@(posedge clk) kill[0] <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(inh[0], 1'b1)
		xfer(1'b1, 8'h00, 32'h8000);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[4], 1'b0)
		// Converter code: clamp then offset
		xfer(1'b1, 8'h08, 32'h7FFF);
		xfer(1'b1, 8'h04, 32'h1234);
		repeat (3) @(posedge clk);
		`CHK(dac[0], 16'h1234)
		xfer(1'b1, 8'h08, 32'h0100);
		xfer(1'b1, 8'h04, 32'hF000);
		xfer(1'b1, 8'h0C, 32'h0010);
		repeat (3) @(posedge clk);
		`CHK(dac[0], 16'hFF10)
		// Step and direction, with the encoder following the shaft
		steps(32'h3, 3);
		ef += 3;
		`CHK(nf, ef)
		`CHK(dir[0], 1'b0)
		steps(32'h10002, 2);
		er += 2;
		`CHK(nr, er)
		`CHK(dir[0], 1'b1)
		xfer(1'b0, 8'h18, 32'h0);
		`CHK(q, 32'(ef - er))
		// Two-pulse form
		mode <= 1'b1;
		xfer(1'b1, 8'h00, 32'h1);
		repeat (10) @(posedge clk);
		steps(32'h2, 2);
		steps(32'h10001, 1);
		ef += 2;
		er += 1;
		`CHK(nf, ef)
		`CHK(nr, er)
		mode <= 1'b0;
		xfer(1'b1, 8'h00, 32'h20);
		repeat (10) @(posedge clk);
		// Held forward limit stops and refuses forward only
		@(posedge clk) fwd[0] <= 1'b1;
		repeat (8) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[0], 1'b1)
		steps(32'h5, 1);
		xfer(1'b0, 8'h10, 32'h0);
		// Refused: nothing pending, direction still the earlier reverse move
		`CHK(q, 32'h0001_0000)
		`CHK(nf, ef)
		steps(32'h10001, 1);
		er += 1;
		`CHK(nr, er)
		// Short limit pulse halts a move but leaves the direction free
		@(posedge clk) fwd[0] <= 1'b0;
		xfer(1'b1, 8'h10, 32'h14);
		repeat (100) @(posedge clk);
		@(posedge clk) fwd[0] <= 1'b1;
		repeat (3) @(posedge clk);
		@(posedge clk) fwd[0] <= 1'b0;
		repeat (200) @(posedge clk);
		ef += 2;
		`CHK(nf, ef)
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[5], 1'b1)
		steps(32'h1, 1);
		ef += 1;
		`CHK(nf, ef)
		// Active-low polarity, then read back while disabled
		xfer(1'b1, 8'h00, 32'h100);
		repeat (8) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[0], 1'b1)
		steps(32'h1, 1);
		ef += 1;
		`CHK(nf, ef)
		xfer(1'b1, 8'h00, 32'h0);
		// Home search: refused, then limit reversal and stop on home
		xfer(1'b1, 8'h00, 32'h2000);
		repeat (5) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[9:8], 2'h0)
		// Start is judged on the enables already stored, so enable first
		xfer(1'b1, 8'h00, 32'h00E0);
		xfer(1'b1, 8'h00, 32'h20E0);
		repeat (200) @(posedge clk);
		`CHK(dir[0], 1'b0)
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[9:8], 2'h1)
		@(posedge clk) fwd[0] <= 1'b1;
		repeat (200) @(posedge clk);
		`CHK(dir[0], 1'b1)
		@(posedge clk) fwd[0] <= 1'b0;
		@(posedge clk) home[0] <= 1'b1;
		repeat (100) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[6], 1'b1)
		`CHK(q[9:8], 2'h0)
		snap = nf + nr;
		repeat (200) @(posedge clk);
		`CHK(nf + nr, snap)
		xfer(1'b1, 8'h00, 32'h0);
		// Home with approach: back off the switch, then creep onto its edge
		@(posedge clk) home[0] <= 1'b0;
		xfer(1'b1, 8'h00, 32'h10E0);
		xfer(1'b1, 8'h00, 32'h30E0);
		repeat (100) @(posedge clk);
		@(posedge clk) home[0] <= 1'b1;
		repeat (100) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[9:8], 2'h2)
		`CHK(dir[0], 1'b1)
		@(posedge clk) home[0] <= 1'b0;
		repeat (100) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(q[9:8], 2'h3)
		`CHK(dir[0], 1'b0)
		@(posedge clk) home[0] <= 1'b1;
		repeat (100) @(posedge clk);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK({q[9:8], q[6]}, 3'h1)
		xfer(1'b1, 8'h00, 32'h0);
		// Axis one encoder: fast edges, both directions, glitches
		foreach (up[i]) quad(up[i], 3);
		xfer(1'b0, 8'h38, 32'h0);
		`CHK(q, 32'h4)
		foreach (dn[i]) quad(dn[i], 3);
		quad(2'h1, 10);
		xfer(1'b0, 8'h38, 32'h0);
		`CHK(q, 32'hFFFFFFFF)
		quad(2'h2, 10);
		quad(2'h1, 1);
		quad(2'h3, 1);
		quad(2'h1, 10);
		xfer(1'b0, 8'h38, 32'h0);
		`CHK(q, 32'hFFFFFFFF)
		// Armed index latches the held count
		xfer(1'b1, 8'h38, 32'h100);
		xfer(1'b1, 8'h20, 32'h10000);
		@(posedge clk) eidx[1] <= 1'b1;
		repeat (6) @(posedge clk);
		@(posedge clk) eidx[1] <= 1'b0;
		xfer(1'b0, 8'h3C, 32'h0);
		`CHK(q, 32'h100)
		xfer(1'b0, 8'h34, 32'h0);
		`CHK(q[7], 1'b1)
		// Inverted step output idles high
		xfer(1'b1, 8'h00, 32'h6);
		repeat (10) @(posedge clk);
		`CHK(stp[0], 1'b1)
		complete_run();
	end
endmodule
`default_nettype wire
